// File: rtl/dcff_pkg.sv
package dcff_pkg;
  // ==========================================================
  // widths
  localparam int DCFF_DATA_W = 18;
  localparam int DCFF_OFF_W = 12;
  localparam int DCFF_DEPTH = 256;
  // ==========================================================
  // reset values
  localparam logic [DCFF_OFF_W-1:0] DCFF_DEF_OFFSET = 12'h0007;
  localparam logic [DCFF_DATA_W-1:0] DCFF_DATA_RST = 18'h0_0000;
  // pad above the offset field when an offset is read back
  localparam int DCFF_PAD_W = DCFF_DATA_W - DCFF_OFF_W;
  // ==========================================================
  // offset register sequence: empty first, then full
  typedef enum logic {
    DCFF_SEL_EMPTY = 1'b0,
    DCFF_SEL_FULL = 1'b1
  } dcff_sel_t;
endpackage

// File: rtl/dcff_mem.sv
module dcff_mem #(
  parameter int DW = 18,
  parameter int AW = 8
) (
  input wire logic clk, // core clock
  input wire logic ce, // clock enable, freezes while low
  input wire logic wr_en, // store one word
  input wire logic [AW-1:0] wr_addr, // write location
  input wire logic [DW-1:0] wr_data, // word to store
  input wire logic rd_en, // fetch one word
  input wire logic [AW-1:0] rd_addr, // read location
  output logic [DW-1:0] rd_data // registered read word
);
  // ==========================================================
  // storage
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port; no reset so it maps onto block ram
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // read port, data held between reads
  always_ff @(posedge clk) begin
    if (ce && rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// File: rtl/dcff_top.sv
// Notes on behaviour
// - eighteen bit words in and out
// - write stores when enabled and not full
// - read advances when enabled and not empty
// - load low: writes go to offset register
// - load low: reads return offset register
// - shared pin: half full or write expansion
// - empty flag low when no words
// - full flag low when buffer full
// - almost empty flag, async or registered
// - almost full flag, async or registered
// - first load strap picks first device
// - uncascaded: shared pin is retransmit strobe
// - expansion outputs feed next device inputs
// - reset empties buffer, clears both positions
// - output enable low drives data outputs, in a chain only while holding the read token
// - write expansion input from previous device
// - two offset registers, alternate, empty first
// - retransmit rewinds read position to zero
// - almost flags at or within offset
//
// Local design decisions: the placing of the registers and strobed register access.
module dcff_top
  import dcff_pkg::*;
#(
  parameter int DEPTH = dcff_pkg::DCFF_DEPTH, // words of storage
  parameter logic [dcff_pkg::DCFF_OFF_W-1:0] DEF_OFFSET =
    dcff_pkg::DCFF_DEF_OFFSET // offset after reset
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic [dcff_pkg::DCFF_DATA_W-1:0] write_data_in, // data in
  input wire logic write_en_n, // write enable, low active
  input wire logic read_en_n, // read enable, low active
  input wire logic output_en_n, // output enable, low active
  input wire logic offset_load_n, // offset access, low active
  input wire logic first_load_or_retransmit, // strap or rewind
  input wire logic cascade_mode, // high when in a depth chain
  input wire logic cascade_write_in, // write token from previous
  input wire logic cascade_read_in, // read token from previous
  input wire logic sync_flag_mode_select, // high: async almost flags
  output logic [dcff_pkg::DCFF_DATA_W-1:0] read_data_out, // data out
  output logic read_data_oe, // drive enable for data out
  output logic half_full_or_cascade_write_out, // half full or token
  output logic cascade_read_out, // read token to next device
  output logic empty_flag_n, // low when empty
  output logic full_flag_n, // low when full
  output logic almost_empty_flag_n, // low when almost empty
  output logic almost_full_flag_n // low when almost full
);
  // ==========================================================
  // derived sizes
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam int CW = (LW > DCFF_OFF_W ? LW : DCFF_OFF_W) + 2;
  localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);
  localparam logic [LW-1:0] HALF_L = LW'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_A = AW'(DEPTH - 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // widen a level or an offset for comparison
  function automatic logic [CW-1:0] widen_lvl(input logic [LW-1:0] v);
    widen_lvl = {{(CW-LW){1'b0}}, v};
  endfunction

  function automatic logic [CW-1:0] widen_off(
      input logic [DCFF_OFF_W-1:0] v);
    widen_off = {{(CW-DCFF_OFF_W){1'b0}}, v};
  endfunction

  // ==========================================================
  // state
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [LW-1:0] level_q;
  logic [LW-1:0] level_d;
  logic [LW-1:0] written_q;
  logic [DCFF_OFF_W-1:0] empty_off_q;
  logic [DCFF_OFF_W-1:0] full_off_q;
  dcff_sel_t wsel_q;
  dcff_sel_t rsel_q;
  logic wtok_q;
  logic rtok_q;
  logic rt_prev_q;
  logic mem_valid_q;
  logic off_valid_q;
  logic [DCFF_DATA_W-1:0] off_data_q;
  logic [DCFF_DATA_W-1:0] mem_rdata;

  // ==========================================================
  // request decode
  logic do_wr;
  logic do_rd;
  logic do_off_wr;
  logic do_off_rd;
  logic do_rt;
  logic wr_allowed;
  logic rd_allowed;

  // tokens only matter in a chain; a lone device always owns both
  assign wr_allowed = !cascade_mode || wtok_q;
  assign rd_allowed = !cascade_mode || rtok_q;
  // retransmit acts on the rising edge of the strobe
  assign do_rt = !cascade_mode && first_load_or_retransmit &&
                 !rt_prev_q;
  // full blocks the write regardless of the enable
  assign do_wr = !write_en_n && offset_load_n && level_q != DEPTH_L &&
                 wr_allowed && !do_rt;
  // empty blocks the read regardless of the enable
  assign do_rd = !read_en_n && offset_load_n && level_q != '0 &&
                 rd_allowed && !do_rt;
  assign do_off_wr = !write_en_n && !offset_load_n;
  assign do_off_rd = !read_en_n && !offset_load_n;

  // ==========================================================
  // fill level; a rewind restores the words written since reset, up to the depth
  always_comb begin
    level_d = level_q;
    if (do_rt) begin
      level_d = written_q;
    end else if (do_wr && !do_rd) begin
      level_d = level_q + LW'(1);
    end else if (do_rd && !do_wr) begin
      level_d = level_q - LW'(1);
    end
  end

  // ==========================================================
  // storage
  dcff_mem #(
    .DW(DCFF_DATA_W),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(do_wr),
    .wr_addr(wptr_q),
    .wr_data(write_data_in),
    .rd_en(do_rd),
    .rd_addr(rptr_q),
    .rd_data(mem_rdata)
  );

  // ==========================================================
  // positions and level
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      level_q <= '0;
    end else if (ce) begin
      level_q <= level_d;
      if (do_wr) begin
        wptr_q <= (wptr_q == LAST_A) ? '0 : wptr_q + AW'(1);
      end
      if (do_rt) begin
        rptr_q <= '0;
      end else if (do_rd) begin
        rptr_q <= (rptr_q == LAST_A) ? '0 : rptr_q + AW'(1);
      end
    end
  end

  // words written since reset, saturating at the depth;
  // rewinding after more writes than that replays garbage order
  always_ff @(posedge clk) begin
    if (rst) begin
      written_q <= '0;
    end else if (ce && do_wr && written_q != DEPTH_L) begin
      written_q <= written_q + LW'(1);
    end
  end

  // retransmit strobe history
  always_ff @(posedge clk) begin
    if (rst) begin
      rt_prev_q <= 1'b0;
    end else if (ce) begin
      rt_prev_q <= first_load_or_retransmit;
    end
  end

  // ==========================================================
  // offset registers, written in turn starting with empty
  always_ff @(posedge clk) begin
    if (rst) begin
      empty_off_q <= DEF_OFFSET;
      full_off_q <= DEF_OFFSET;
      wsel_q <= DCFF_SEL_EMPTY;
    end else if (ce && do_off_wr) begin
      if (wsel_q == DCFF_SEL_EMPTY) begin
        empty_off_q <= write_data_in[DCFF_OFF_W-1:0];
        wsel_q <= DCFF_SEL_FULL;
      end else begin
        full_off_q <= write_data_in[DCFF_OFF_W-1:0];
        wsel_q <= DCFF_SEL_EMPTY;
      end
    end
  end

  // offset read-back follows its own sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      rsel_q <= DCFF_SEL_EMPTY;
      off_data_q <= DCFF_DATA_RST;
    end else if (ce && do_off_rd) begin
      if (rsel_q == DCFF_SEL_EMPTY) begin
        off_data_q <= {{DCFF_PAD_W{1'b0}}, empty_off_q};
        rsel_q <= DCFF_SEL_FULL;
      end else begin
        off_data_q <= {{DCFF_PAD_W{1'b0}}, full_off_q};
        rsel_q <= DCFF_SEL_EMPTY;
      end
    end
  end

  // ==========================================================
  // output register; one extra stage so the pins come from a
  // flop whichever source was read, at the cost of a cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_valid_q <= 1'b0;
      off_valid_q <= 1'b0;
    end else if (ce) begin
      mem_valid_q <= do_rd;
      off_valid_q <= do_off_rd;
    end
  end

  // an empty buffer keeps showing the last word read
  always_ff @(posedge clk) begin
    if (rst) begin
      read_data_out <= DCFF_DATA_RST;
    end else if (ce) begin
      if (off_valid_q) begin
        read_data_out <= off_data_q;
      end else if (mem_valid_q) begin
        read_data_out <= mem_rdata;
      end
    end
  end

  // only the device holding the read token drives a shared bus
  assign read_data_oe = !output_en_n && rd_allowed;

  // ==========================================================
  // boundary flags
  always_ff @(posedge clk) begin
    if (rst) begin
      empty_flag_n <= 1'b0;
      full_flag_n <= 1'b1;
    end else if (ce) begin
      empty_flag_n <= (level_d != '0);
      full_flag_n <= (level_d != DEPTH_L);
    end
  end

  // ==========================================================
  // almost flags
  logic ae_now;
  logic af_now;
  logic ae_q;
  logic af_q;

  assign ae_now = widen_lvl(level_q) <= widen_off(empty_off_q);
  assign af_now = widen_lvl(level_q) + widen_off(full_off_q) >=
                  DEPTH_C;

  // registered copies, one cycle behind the level
  always_ff @(posedge clk) begin
    if (rst) begin
      ae_q <= 1'b1;
      af_q <= 1'b0;
    end else if (ce) begin
      ae_q <= ae_now;
      af_q <= af_now;
    end
  end

  // mode pin high picks the direct decode
  assign almost_empty_flag_n = sync_flag_mode_select ? !ae_now :
                               !ae_q;
  assign almost_full_flag_n = sync_flag_mode_select ? !af_now :
                              !af_q;

  // ==========================================================
  // depth expansion tokens
  logic wx_pulse_q;
  logic hf_n_q;

  // the strap is sampled while reset is held, never asynchronously
  always_ff @(posedge clk) begin
    if (rst) begin
      wtok_q <= !first_load_or_retransmit;
      rtok_q <= !first_load_or_retransmit;
    end else if (ce) begin
      if (cascade_write_in) begin
        wtok_q <= 1'b1;
      end else if (do_wr && wptr_q == LAST_A) begin
        wtok_q <= 1'b0;
      end
      if (cascade_read_in) begin
        rtok_q <= 1'b1;
      end else if (do_rd && rptr_q == LAST_A) begin
        rtok_q <= 1'b0;
      end
    end
  end

  // hand-off pulses when the last location is used
  always_ff @(posedge clk) begin
    if (rst) begin
      wx_pulse_q <= 1'b0;
      cascade_read_out <= 1'b0;
      hf_n_q <= 1'b1;
    end else if (ce) begin
      wx_pulse_q <= cascade_mode && do_wr && wptr_q == LAST_A;
      cascade_read_out <= cascade_mode && do_rd &&
                          rptr_q == LAST_A;
      hf_n_q <= !(level_d > HALF_L);
    end
  end

  // shared pin: token pulse in a chain, half full otherwise
  assign half_full_or_cascade_write_out = cascade_mode ? wx_pulse_q :
                                          hf_n_q;
endmodule

// File: tb/dcff_monitor.sv
module dcff_monitor
  import dcff_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic write_en_n, // write
  input wire logic read_en_n, // read
  input wire logic output_en_n, // drive
  input wire logic offset_load_n, // load
  input wire logic first_load_or_retransmit, // rewind
  input wire logic cascade_mode, // chain
  input wire logic sync_flag_mode_select, // flag mode
  input wire logic [dcff_pkg::DCFF_DATA_W-1:0] read_data_out, // data
  input wire logic read_data_oe, // data drive
  input wire logic half_full_or_cascade_write_out, // half
  input wire logic empty_flag_n, // empty
  input wire logic full_flag_n, // full
  input wire logic almost_empty_flag_n // almost empty
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // checks, all on the core clock
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_drive: assert property (
    !cascade_mode |-> read_data_oe == !output_en_n)
    else $error("data drive not set by output enable");
  a_rst_empty: assert property (
    $past(rst) |-> !empty_flag_n && full_flag_n)
    else $error("not empty after reset");
  a_wr_fills: assert property (
    ce && !write_en_n && offset_load_n && full_flag_n && !cascade_mode
    && !first_load_or_retransmit |=> empty_flag_n)
    else $error("write left device empty");
  a_full_holds: assert property (
    !full_flag_n && read_en_n |=> !full_flag_n)
    else $error("full dropped with no read");
  a_empty_holds: assert property (
    !empty_flag_n && write_en_n && !first_load_or_retransmit
    |=> first_load_or_retransmit || !empty_flag_n)
    else $error("empty dropped with no write");
  // a word moves to the output one edge after its read
  a_rd_hold: assert property (
    ce && read_en_n |=> ##1 $stable(read_data_out))
    else $error("output moved without a read");
  a_half_full: assert property (
    !cascade_mode && !full_flag_n |-> !half_full_or_cascade_write_out)
    else $error("half full missing when full");
  a_ae_async: assert property (
    sync_flag_mode_select && !empty_flag_n |-> !almost_empty_flag_n)
    else $error("almost empty missing when empty");
endmodule

bind dcff_top dcff_monitor u_dcff_monitor (.clk, .rst, .ce, .write_en_n,
  .read_en_n, .output_en_n, .offset_load_n, .first_load_or_retransmit,
  .cascade_mode, .sync_flag_mode_select, .read_data_out, .read_data_oe,
  .half_full_or_cascade_write_out, .empty_flag_n, .full_flag_n,
  .almost_empty_flag_n);

// File: tb/dcff_peer.sv
module dcff_peer
  import dcff_pkg::*;
(
  input wire logic clk, // core clock
  output logic [dcff_pkg::DCFF_DATA_W-1:0] write_data_in, // word out
  output logic write_en_n, // write request
  output logic read_en_n // read request
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle until asked
  initial begin
    write_data_in = 18'h0_0000;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
  end
  // back-to-back writes counting up from base; the data is inverted
  // afterwards so late sampling picks up garbage, not the word
  task automatic wr(input int n, input logic [DCFF_DATA_W-1:0] base);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      write_en_n <= 1'b0;
      write_data_in <= base + DCFF_DATA_W'(i);
      @(posedge clk);
    end
    write_en_n <= 1'b1;
    write_data_in <= ~write_data_in;
  endtask
  // one read request lasting one edge
  task automatic rd();
    @(posedge clk);
    read_en_n <= 1'b0;
    @(posedge clk);
    read_en_n <= 1'b1;
  endtask
endmodule

// File: tb/dcff_top_tb.sv
module dcff_top_tb;
  import dcff_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // small depth keeps fill and drain short
  localparam int DEPTH = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic output_en_n = 1'b0;
  logic offset_load_n = 1'b1;
  logic rt = 1'b0;
  logic flag_async = 1'b0;
  logic casc = 1'b0;
  logic wx_in = 1'b0;
  logic rx_in = 1'b0;
  logic rx_out;
  logic [DCFF_DATA_W-1:0] wdata, rdata;
  logic wen_n, ren_n, oe, half_n, empty_n, full_n, aempty_n, afull_n;
  int fail_count = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  // device and its writer and reader; chain pins driven by the bench
  dcff_top #(.DEPTH(DEPTH)) u_dcff_top (.clk(clk), .rst(rst), .ce(1'b1),
    .write_data_in(wdata), .write_en_n(wen_n), .read_en_n(ren_n),
    .output_en_n(output_en_n), .offset_load_n(offset_load_n),
    .first_load_or_retransmit(rt), .cascade_mode(casc),
    .cascade_write_in(wx_in), .cascade_read_in(rx_in),
    .sync_flag_mode_select(flag_async), .read_data_out(rdata),
    .read_data_oe(oe), .half_full_or_cascade_write_out(half_n),
    .cascade_read_out(rx_out), .empty_flag_n(empty_n),
    .full_flag_n(full_n),
    .almost_empty_flag_n(aempty_n), .almost_full_flag_n(afull_n));
  dcff_peer u_dcff_peer (.clk(clk), .write_data_in(wdata),
    .write_en_n(wen_n), .read_en_n(ren_n));
  // ==========================================================
  // compares and the verdict
  task automatic chk_word(input logic [DCFF_DATA_W-1:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // scenarios; the device owes nothing before its first reset
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  // word shows one edge after the read edge
  task automatic t_read(input logic [DCFF_DATA_W-1:0] exp);
    u_dcff_peer.rd();
    @(posedge clk);
    #1;
    chk_word(rdata, exp);
  endtask
  task automatic t_reset_state();
    do_reset();
    #1;
    chk_bit(empty_n, 1'b0);
    chk_bit(full_n, 1'b1);
    chk_word(rdata, 18'h0_0000);
    chk_bit(half_n, 1'b1);
    chk_bit(aempty_n, 1'b0);
    chk_bit(afull_n, 1'b1);
    @(posedge clk);
    output_en_n <= 1'b1;
    #1;
    chk_bit(oe, 1'b0);
    @(posedge clk);
    output_en_n <= 1'b0;
    #1;
    chk_bit(oe, 1'b1);
  endtask
  // one write past full is dropped; one read past empty keeps the word
  task automatic t_fill_drain();
    do_reset();
    u_dcff_peer.wr(DEPTH + 1, 18'h1_0000);
    #1;
    chk_bit(full_n, 1'b0);
    chk_bit(half_n, 1'b0);
    chk_bit(aempty_n, 1'b1);
    chk_bit(afull_n, 1'b0);
    for (int i = 0; i < DEPTH; i++)
      t_read(18'h1_0000 + DCFF_DATA_W'(i));
    chk_bit(empty_n, 1'b0);
    t_read(18'h1_0000 + DCFF_DATA_W'(DEPTH - 1));
  endtask
  // third offset write wraps to empty; upper data bits are dropped
  task automatic t_offsets();
    do_reset();
    @(posedge clk);
    offset_load_n <= 1'b0;
    u_dcff_peer.wr(3, 18'h3_F002);
    #1;
    chk_bit(empty_n, 1'b0);
    t_read(18'h0_0004);
    t_read(18'h0_0003);
    t_read(18'h0_0004);
    @(posedge clk);
    offset_load_n <= 1'b1;
    flag_async <= 1'b1;
    u_dcff_peer.wr(4, 18'h2_0000);
    #1;
    chk_bit(aempty_n, 1'b0);
    chk_bit(afull_n, 1'b1);
    u_dcff_peer.wr(1, 18'h2_0004);
    #1;
    chk_bit(aempty_n, 1'b1);
    chk_bit(afull_n, 1'b0);
  endtask
  // rewind after a full drain replays from the first word
  task automatic t_retransmit();
    do_reset();
    u_dcff_peer.wr(3, 18'h2_AAA0);
    for (int i = 0; i < 3; i++)
      t_read(18'h2_AAA0 + DCFF_DATA_W'(i));
    @(posedge clk);
    rt <= 1'b1;
    @(posedge clk);
    rt <= 1'b0;
    @(posedge clk);
    #1;
    chk_bit(empty_n, 1'b1);
    t_read(18'h2_AAA0);
  endtask
  // chain member: strap picks token owner, hand-off pulses at the
  // last location, and a device without the read token stops driving
  task automatic t_cascade();
    @(posedge clk);
    casc <= 1'b1;
    rt <= 1'b1;
    do_reset();
    #1;
    chk_bit(oe, 1'b0);
    @(posedge clk);
    rt <= 1'b0;
    do_reset();
    #1;
    chk_bit(oe, 1'b1);
    u_dcff_peer.wr(DEPTH, 18'h0_5A00);
    #1;
    chk_bit(half_n, 1'b1);
    chk_bit(full_n, 1'b0);
    @(posedge clk);
    #1;
    chk_bit(half_n, 1'b0);
    for (int i = 0; i < DEPTH - 1; i++)
      t_read(18'h0_5A00 + DCFF_DATA_W'(i));
    u_dcff_peer.rd();
    #1;
    chk_bit(rx_out, 1'b1);
    chk_bit(oe, 1'b0);
    @(posedge clk);
    #1;
    chk_word(rdata, 18'h0_5A00 + DCFF_DATA_W'(DEPTH - 1));
    chk_bit(rx_out, 1'b0);
    // no write token now, so this word must be refused
    u_dcff_peer.wr(1, 18'h0_1111);
    #1;
    chk_bit(empty_n, 1'b0);
    @(posedge clk);
    wx_in <= 1'b1;
    rx_in <= 1'b1;
    @(posedge clk);
    wx_in <= 1'b0;
    rx_in <= 1'b0;
    #1;
    chk_bit(oe, 1'b1);
    u_dcff_peer.wr(1, 18'h0_2222);
    #1;
    chk_bit(empty_n, 1'b1);
    t_read(18'h0_2222);
  endtask
  // main sequence
  initial begin
    t_reset_state();
    t_fill_drain();
    t_offsets();
    t_retransmit();
    t_cascade();
    print_verdict();
  end
  // watchdog, far beyond the some 155 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
